//--- logic/byte_timing.sv
// Byte clock start-up and HS/FS byte pacing of the parallel interface
`timescale 1ns/1ps
module byte_timing
   import byte_timing_pkg::*;
#(
   parameter int unsigned FIRST_EDGE_CYCLES = FIRST_EDGE_CYC,
   parameter int unsigned ACCURACY_CYCLES   = ACCURACY_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Suspend pin, low while suspended
   input  wire logic       suspend_low_input,
   // Clock outputs
   output logic            byte_clock_out,
   output logic            clock_valid,
   // Mode select, high for full speed
   input  wire logic       xcvr_select,
   // Shared data bus
   input  wire logic [7:0] data_in,
   output logic [7:0]      data_out,
   output logic            data_oe,
   // Transmit handshake
   input  wire logic       txvalid,
   output logic            txready,
   // Transmit byte towards the serialiser
   output logic [7:0]      tx_byte,
   output logic            tx_byte_strobe,
   // Receive byte from the recovery logic
   input  wire rx_in_type  rx_in,
   // Receive handshake
   output logic            rxactive,
   output logic            rxvalid
);

   state_type  state_reg;
   state_type  state_next;
   logic       fs_mode;
   logic       clk_on;
   logic [5:0] rx_len;

   // Only the interface timing differs between modes, never the clock
   assign fs_mode = (xcvr_select == XCVR_FS);
   assign clk_on  = (state_reg.startup == ST_LOCKING) ||
                    (state_reg.startup == ST_RUNNING);
   // Each stuffed bit adds one bit time to the byte boundary
   always_comb begin
      unique case (rx_in.stuffed)
         2'h0: begin
            rx_len = FS_BYTE_CYC;
         end
         2'h1: begin
            rx_len = FS_BYTE_CYC + FS_STUFF_CYC;
         end
         2'h2: begin
            rx_len = FS_BYTE_CYC + (FS_STUFF_CYC << 1);
         end
         default: begin
            // More than two stuffed bits cannot occur in one byte
            rx_len = FS_BYTE_CYC + (FS_STUFF_CYC << 1);
         end
      endcase
   end

   always_comb begin
      state_next = state_reg;
      state_next.tx_strobe = 1'b0;
      state_next.txready   = 1'b0;
      state_next.rx_valid  = 1'b0;

      // Pin synchroniser; the level moves when stages two and three agree
      state_next.sus_sync = {state_reg.sus_sync[1:0], suspend_low_input};
      if (state_reg.sus_sync[2] == state_reg.sus_sync[1]) begin
         state_next.awake = state_reg.sus_sync[2];
      end

      // Start-up of the multiplied clock and its byte clock divider
      unique case (state_reg.startup)
         ST_OFF: begin
            state_next.start_cnt = '0;
            if (state_reg.awake) begin
               state_next.startup = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            state_next.start_cnt = state_reg.start_cnt + 1'b1;
            if (state_reg.start_cnt ==
                START_CNT_W'(FIRST_EDGE_CYCLES - 1)) begin
               state_next.startup   = ST_LOCKING;
               state_next.start_cnt = '0;
            end
         end
         ST_LOCKING: begin
            state_next.start_cnt = state_reg.start_cnt + 1'b1;
            if (state_reg.start_cnt ==
                START_CNT_W'(ACCURACY_CYCLES - 1)) begin
               state_next.startup   = ST_RUNNING;
               state_next.clk_valid = 1'b1;
            end
         end
         ST_RUNNING: begin
            state_next.start_cnt = '0;
         end
      endcase
      if (!state_reg.awake) begin
         state_next.startup   = ST_OFF;
         state_next.clk_valid = 1'b0;
      end

      // Byte clock toggles only once started
      state_next.byte_clk = clk_on ? ~state_reg.byte_clk : 1'b0;

      // Transmit pacing
      if (state_reg.tx_cnt != '0) begin
         state_next.tx_cnt = state_reg.tx_cnt - 1'b1;
      end
      if (clk_on && txvalid) begin
         if (!fs_mode) begin
            // One byte taken every cycle
            state_next.txready   = 1'b1;
            state_next.tx_strobe = 1'b1;
            state_next.tx_byte   = data_in;
         end else if (state_reg.tx_cnt == '0) begin
            // One take per byte time; engine may keep the byte up
            state_next.txready   = 1'b1;
            state_next.tx_strobe = 1'b1;
            state_next.tx_byte   = data_in;
            state_next.tx_cnt    = FS_BYTE_CYC - 1'b1;
         end
      end else if (!txvalid) begin
         state_next.tx_cnt = '0;
      end

      // Receive pacing
      if (state_reg.rx_cnt != '0) begin
         state_next.rx_cnt = state_reg.rx_cnt - 1'b1;
      end
      if (clk_on && rx_in.strobe) begin
         if (!fs_mode) begin
            state_next.rx_valid = 1'b1;
            state_next.rx_data  = rx_in.data;
         end else begin
            state_next.rx_pend      = 1'b1;
            state_next.rx_pend_data = rx_in.data;
            state_next.rx_pend_len  = rx_len;
         end
      end
      // Full speed bytes go out once per byte boundary and stay on the bus
      if (state_reg.rx_pend && state_reg.rx_cnt == '0) begin
         state_next.rx_valid = 1'b1;
         state_next.rx_data  = state_reg.rx_pend_data;
         state_next.rx_cnt   = state_reg.rx_pend_len - 1'b1;
         if (!(clk_on && rx_in.strobe)) begin
            state_next.rx_pend = 1'b0;
         end
      end
      // Packet end waits until no byte is left to hand over
      if (state_reg.rx_end_pend && !state_reg.rx_pend &&
          state_reg.rx_cnt == '0) begin
         state_next.rx_active   = 1'b0;
         state_next.rx_end_pend = 1'b0;
      end
      // A start or end seen in the closing cycle wins over the close
      if (clk_on && rx_in.sop) begin
         state_next.rx_active = 1'b1;
      end
      if (clk_on && rx_in.eop) begin
         state_next.rx_end_pend = 1'b1;
      end

      if (!clk_on) begin
         state_next.rx_active   = 1'b0;
         state_next.rx_valid    = 1'b0;
         state_next.rx_pend     = 1'b0;
         state_next.rx_end_pend = 1'b0;
         state_next.txready     = 1'b0;
         state_next.tx_strobe   = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '{sus_sync: 3'h0, awake: 1'b0, startup: ST_OFF,
                        start_cnt: '0, byte_clk: 1'b0, clk_valid: 1'b0,
                        tx_cnt: '0, txready: 1'b0, tx_strobe: 1'b0,
                        tx_byte: 8'h00, rx_active: 1'b0, rx_valid: 1'b0,
                        rx_data: 8'h00, rx_cnt: '0, rx_pend: 1'b0,
                        rx_pend_data: 8'h00, rx_pend_len: '0,
                        rx_end_pend: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign byte_clock_out = state_reg.byte_clk;
   assign clock_valid    = state_reg.clk_valid;
   assign txready        = state_reg.txready;
   assign tx_byte        = state_reg.tx_byte;
   assign tx_byte_strobe = state_reg.tx_strobe;
   assign rxactive       = state_reg.rx_active;
   assign rxvalid        = state_reg.rx_valid && state_reg.rx_active;
   assign data_out       = state_reg.rx_data;
   // Device drives the bus only while no transmit is offered
   assign data_oe        = clk_on && !txvalid;

endmodule // byte_timing

//--- logic/byte_timing_pkg.sv
// Constants and state types for the byte clock and byte timing block
package byte_timing_pkg;

   // Core clock period and the start-up figures in their own units
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned FIRST_EDGE_NS  = 5600000;
   localparam int unsigned ACCURACY_NS    = 1400000;
   // Longest times round down to whole cycles, never below one
   localparam int unsigned FIRST_EDGE_CYC =
      (FIRST_EDGE_NS / CLK_PERIOD_NS) > 0 ? FIRST_EDGE_NS / CLK_PERIOD_NS : 1;
   localparam int unsigned ACCURACY_CYC   =
      (ACCURACY_NS / CLK_PERIOD_NS) > 0 ? ACCURACY_NS / CLK_PERIOD_NS : 1;
   localparam int unsigned START_CNT_W    = 17;

   // Clock plan: reference, multiplied clock, byte clock (MHz)
   localparam int unsigned REF_MHZ        = 24;
   localparam int unsigned PLL_MHZ        = 480;
   localparam int unsigned BYTE_MHZ       = 60;
   localparam int unsigned PLL_DIVIDE     = PLL_MHZ / BYTE_MHZ;

   // Full-speed pacing in core clock cycles
   localparam int unsigned FS_CYC_PER_BIT = 5;
   localparam int unsigned BITS_PER_BYTE  = 8;
   localparam logic [5:0]  FS_BYTE_CYC    = 6'h28;
   localparam logic [5:0]  FS_STUFF_CYC   = 6'h05;
   localparam int unsigned PACE_W         = 6;

   // Mode select level for full speed
   localparam logic        XCVR_FS        = 1'b1;

   // Start-up sequence, Gray coded along the usual path
   typedef enum logic [1:0] {
      ST_OFF     = 2'b00,
      ST_SETTLE  = 2'b01,
      ST_LOCKING = 2'b11,
      ST_RUNNING = 2'b10
   } startup_type;

   // Receive byte offered by the recovery logic
   typedef struct packed {
      logic       sop;
      logic       eop;
      logic       strobe;
      logic [1:0] stuffed;
      logic [7:0] data;
   } rx_in_type;

   // Whole state of the block
   typedef struct packed {
      logic [2:0]             sus_sync;
      logic                   awake;
      startup_type            startup;
      logic [START_CNT_W-1:0] start_cnt;
      logic                   byte_clk;
      logic                   clk_valid;
      logic [PACE_W-1:0]      tx_cnt;
      logic                   txready;
      logic                   tx_strobe;
      logic [7:0]             tx_byte;
      logic                   rx_active;
      logic                   rx_valid;
      logic [7:0]             rx_data;
      logic [PACE_W-1:0]      rx_cnt;
      logic                   rx_pend;
      logic [7:0]             rx_pend_data;
      logic [PACE_W-1:0]      rx_pend_len;
      logic                   rx_end_pend;
   } state_type;

endpackage

//--- verification/byte_timing_asserts.sv
// Checker for byte pacing and handshakes of byte_timing
`timescale 1ns/1ps
module byte_timing_asserts
   import byte_timing_pkg::*;
(
   // Clock, reset and status
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       byte_clock_out,
   input wire logic       clock_valid,
   input wire logic       xcvr_select,
   // Bus and handshakes
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic [7:0] tx_byte,
   input wire logic       data_oe,
   input wire logic       txvalid,
   input wire logic       txready,
   input wire logic       tx_byte_strobe,
   input wire logic       rxactive,
   input wire logic       rxvalid,
   input wire rx_in_type  rx_in
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_take; txready |-> $past(txvalid) && tx_byte_strobe; endproperty
   property p_byte; txready |-> tx_byte == $past(data_in); endproperty
   property p_fstx; xcvr_select && txready |=> !txready [*8]; endproperty
   property p_hstx;
      clock_valid && !xcvr_select && txvalid |=> txready;
   endproperty
   property p_oe; clock_valid |-> data_oe == !txvalid; endproperty
   property p_fsrx; xcvr_select && rxvalid |=> !rxvalid [*8]; endproperty
   property p_frame; $rose(rxactive) |-> $past(rx_in.sop); endproperty
   property p_hold;
      xcvr_select && rxvalid |=> $stable(data_out) [*8];
   endproperty
   property p_bclk;
      clock_valid |=> byte_clock_out != $past(byte_clock_out);
   endproperty
   a_take: assert property (p_take) else $error("txready w/o take");
   a_byte: assert property (p_byte) else $error("wrong byte taken");
   a_fstx: assert property (p_fstx) else $error("fs txready twice");
   a_hstx: assert property (p_hstx) else $error("hs take missed");
   a_oe: assert property (p_oe) else $error("bus direction wrong");
   a_fsrx: assert property (p_fsrx) else $error("fs rxvalid twice");
   a_frame: assert property (p_frame) else $error("frame w/o sop");
   a_hold: assert property (p_hold) else $error("fs byte not held");
   a_bclk: assert property (p_bclk) else $error("byte clock stuck");
   c_fstx: cover property (xcvr_select && txready);
   c_fsrx: cover property (xcvr_select && rxvalid);
   c_frame: cover property ($fell(rxactive));
endmodule // byte_timing_asserts

bind byte_timing byte_timing_asserts byte_timing_asserts_i (
   .clk(clk), .srst(srst), .byte_clock_out(byte_clock_out),
   .clock_valid(clock_valid), .xcvr_select(xcvr_select),
   .data_in(data_in), .data_out(data_out), .tx_byte(tx_byte),
   .data_oe(data_oe), .txvalid(txvalid), .txready(txready),
   .tx_byte_strobe(tx_byte_strobe), .rxactive(rxactive),
   .rxvalid(rxvalid), .rx_in(rx_in));

//--- verification/byte_timing_tb.sv
// Self-checking bench for byte_timing with an engine-side model
`timescale 1ns/1ps
module byte_timing_tb;
   import byte_timing_pkg::*;
   logic        clk, srst, suspend_low_input, xcvr_select, start;
   logic        byte_clock_out, clock_valid, data_oe, txvalid, txready;
   logic        tx_byte_strobe, rxactive, rxvalid;
   logic [7:0]  data_in, data_out, tx_byte, n_bytes, rx_last;
   rx_in_type   rx_in;
   int          n_mismatch, cmp_count, cyc;
   logic [31:0] tx_q[$], rx_q[$];

   byte_timing #(.FIRST_EDGE_CYCLES(8), .ACCURACY_CYCLES(8)) byte_timing_i (
      .clk(clk), .srst(srst), .suspend_low_input(suspend_low_input),
      .byte_clock_out(byte_clock_out), .clock_valid(clock_valid),
      .xcvr_select(xcvr_select), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .txvalid(txvalid), .txready(txready),
      .tx_byte(tx_byte), .tx_byte_strobe(tx_byte_strobe), .rx_in(rx_in),
      .rxactive(rxactive), .rxvalid(rxvalid));
   sie_model sie_model_i (
      .clk(clk), .srst(srst), .xcvr_select(xcvr_select), .start(start),
      .n_bytes(n_bytes), .txready(txready), .rxactive(rxactive),
      .rxvalid(rxvalid), .data_out(data_out), .txvalid(txvalid),
      .data_in(data_in), .rx_last(rx_last));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Stamps each taken and each delivered byte with its cycle
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_byte_strobe) tx_q.push_back({cyc[23:0], tx_byte});
      if (rxvalid) rx_q.push_back({cyc[23:0], data_out});
      if (cyc == 1000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d, mismatched %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic t_start;
      int   n;
      logic b;
      n = 0;
      srst <= 1'b0;
      suspend_low_input <= 1'b1;
      while (clock_valid !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(n >= 16 && n <= 24, 1'b1);
      b = byte_clock_out;
      @(posedge clk);
      chk(byte_clock_out, !b);
      $display("test start done");
   endtask

   task automatic t_tx(input logic fs, input logic [7:0] n, input int gap);
      xcvr_select <= fs;
      start <= 1'b1;
      n_bytes <= n;
      tx_q.delete();
      @(posedge clk);
      start <= 1'b0;
      repeat (100) @(posedge clk);
      chk(tx_q.size(), n);
      foreach (tx_q[k]) begin
         chk(tx_q[k][31:8] - tx_q[0][31:8], gap*k);
         chk(tx_q[k][7:0], 8'h10 + k);
      end
      $display("test tx done, full speed %0d", fs);
   endtask

   task automatic rx_send(input logic s, e, st, input logic [1:0] sf,
                          input logic [7:0] d, input int n);
      rx_in <= '{s, e, st, sf, d};
      @(posedge clk);
      if (n > 0) begin
         rx_in <= '0;
         repeat (n) @(posedge clk);
      end
   endtask

   task automatic t_hs_rx;
      xcvr_select <= 1'b0;
      rx_q.delete();
      rx_send(1, 0, 0, 0, 8'h00, 0);
      rx_send(0, 0, 1, 0, 8'ha1, 0);
      rx_send(0, 0, 1, 0, 8'ha2, 0);
      rx_send(0, 1, 0, 0, 8'h00, 5);
      chk(rx_q.size(), 2);
      chk(rx_q[1] - rx_q[0], 32'h101);
      chk(rx_last, 8'ha2);
      chk(rxactive, 1'b0);
      $display("test hs_rx done");
   endtask

   task automatic t_fs_rx;
      xcvr_select <= 1'b1;
      rx_q.delete();
      rx_send(1, 0, 0, 0, 8'h00, 0);
      rx_send(0, 0, 1, 0, 8'hb0, 29);
      rx_send(0, 0, 1, 1, 8'hb1, 29);
      rx_send(0, 0, 1, 2, 8'hb2, 29);
      rx_send(0, 0, 1, 0, 8'hb3, 60);
      rx_send(0, 1, 0, 0, 8'h00, 60);
      chk(rx_q.size(), 4);
      chk(rx_q[1] - rx_q[0], 32'h2801);
      chk(rx_q[2] - rx_q[1], 32'h2d01);
      chk(rx_q[3] - rx_q[2], 32'h3201);
      chk(rxactive, 1'b0);
      $display("test fs_rx done");
   endtask

   initial begin
      srst = 1'b1;
      suspend_low_input = 1'b0;
      xcvr_select = 1'b0;
      start = 1'b0;
      n_bytes = 8'h00;
      rx_in = '0;
      repeat (4) @(posedge clk);
      t_start();
      t_tx(1'b0, 8'h04, 1);
      t_tx(1'b1, 8'h03, 40);
      t_hs_rx();
      t_fs_rx();
      give_verdict();
   end
endmodule // byte_timing_tb

//--- verification/sie_model.sv
// Engine-side model: sends transmit bursts and captures receive bytes
`timescale 1ns/1ps
module sie_model (
   // Clock, reset, mode and burst request
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       xcvr_select,
   input  wire logic       start,
   input  wire logic [7:0] n_bytes,
   // Parallel interface
   input  wire logic       txready,
   input  wire logic       rxactive,
   input  wire logic       rxvalid,
   input  wire logic [7:0] data_out,
   output logic            txvalid,
   output logic [7:0]      data_in,
   output logic [7:0]      rx_last
);
   logic [7:0] left_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         txvalid  <= 1'b0;
         data_in  <= 8'h00;
         left_reg <= 8'h00;
         rx_last  <= 8'h00;
      end else begin
         if (rxactive && rxvalid) rx_last <= data_out;
         if (start) begin
            txvalid  <= 1'b1;
            data_in  <= 8'h10;
            left_reg <= n_bytes;
         // High speed takes every cycle, full speed waits for txready
         end else if (txvalid && (!xcvr_select || txready)) begin
            txvalid  <= left_reg != 8'h01;
            data_in  <= data_in + 8'h01;
            left_reg <= left_reg - 8'h01;
         end else if (!txvalid) data_in <= ~data_in; // Released bus
      end // Otherwise the byte stays for the byte time
   end
endmodule // sie_model
